// [include/usb_attach_defs.vh]
// constants for the usb attach, detach, wake and power control block
`ifndef USB_ATTACH_DEFS_VH
`define USB_ATTACH_DEFS_VH

// register map (word addresses on the plain register port)
`define REG_ADDR_W        4
`define REG_CTRL          4'h0
`define REG_LINE_SEL      4'h1
`define REG_MAX_POWER     4'h2
`define REG_STATUS        4'h3
`define REG_INT_STATUS    4'h4
`define REG_INT_CLEAR     4'h5
`define REG_INT_ENABLE    4'h6

// control register fields
`define CTRL_READY        0
`define CTRL_PULLUP_EXT   1
`define CTRL_SELF_POWER   2
`define CTRL_AUDIO_EP     3
`define CTRL_WAKE_REQ     4
`define CTRL_REMOTE_WAKE  5
`define CTRL_RST          6'h00

// line select fields (general purpose line numbers)
`define GPL_W             4
`define GPL_N             16
`define SEL_SENSE_LSB     0
`define SEL_DETACH_LSB    4
`define SEL_WAKE_LSB      8
`define SEL_PULLUP_LSB    12
`define LINE_SEL_RST      16'h0000

// max power setting, in 2 ma units, 100 ma default
`define MAX_POWER_W       8
`define MAX_POWER_RST     8'h32

// interrupt event bits
`define EV_N              5
`define EV_POWER_UP       0
`define EV_POWER_DOWN     1
`define EV_DETACH         2
`define EV_ATTACH         3
`define EV_SUSPEND        4

// edge detector idle levels after reset
`define POWER_IDLE        1'b1
`define LINK_IDLE         1'b0

// link states
`define ST_W              2
`define ST_OFF            2'h0
`define ST_CONNECTED      2'h1
`define ST_SUSPENDED      2'h2
`define ST_DETACHED       2'h3

`endif

// [logic/usb_attach_detach_control.v]
// attach, detach, wake and power negotiation control of a full speed usb peripheral port
//
// Contract
// - port acts only as a full speed peripheral, never as host.
// - endpoint set selectable between host interface and audio arrangement.
// - d plus pull-up applied only when ready for enumeration.
// - setting chooses internal or external line pull-up; internal after reset.
// - self powered: no pull-up while bus power rail sensed absent.
// - bus power sense line number taken from a setting.
// - detach input and wake output each routed by a line setting.
// - detach high floats both data lines and drops the pull-up.
// - detach low restores pull-up and awaits enumeration.
// - wake output active high, only while detach is asserted.
// - no in-band remote wake while detached.
// - bus powered demand reported as 100 ma unless configured otherwise.
// - reported maximum power taken from a configurable setting.
// - device accepts suspend from the host.
// - bus powered device keeps radio stopped during suspend.
// - indicators and amplifiers switched off during suspend.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "usb_attach_defs.vh"

module usb_attach_detach_control (
  input  wire                     ref_clk_i,
  input  wire                     rst_i,
  input  wire [`REG_ADDR_W-1:0]   reg_addr_i,
  input  wire [15:0]              reg_wdata_i,
  input  wire                     reg_write_i,
  input  wire                     reg_read_i,
  output reg  [15:0]              reg_rdata_o,
  input  wire [`GPL_N-1:0]        general_purpose_line_i,
  output reg  [`GPL_N-1:0]        general_purpose_line_o,
  output reg  [`GPL_N-1:0]        general_purpose_line_oe_n_o,
  output reg                      dplus_line_oe_n_o,
  output reg                      dminus_line_oe_n_o,
  output reg                      pullup_internal_o,
  input  wire                     host_suspend_i,
  input  wire                     bus_reset_i,
  output reg                      peripheral_mode_o,
  output reg                      audio_endpoints_o,
  output reg  [`MAX_POWER_W-1:0]  max_power_setting_o,
  output reg                      remote_wake_o,
  output reg                      radio_enable_o,
  output reg                      aux_power_enable_o,
  output reg                      irq_o
);

  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  reg [5:0]               ctrl;
  reg [15:0]              line_sel;
  reg [`MAX_POWER_W-1:0]  max_power;
  reg [`EV_N-1:0]         int_status;
  reg [`EV_N-1:0]         int_enable;
  reg [`ST_W-1:0]         state;
  reg [`ST_W-1:0]         next_state;
  wire [`GPL_N-1:0]       gpl_sync;
  wire                    susp_sync;
  wire                    power_rise;
  wire                    power_fall;
  wire                    detach_rise;
  wire                    detach_fall;
  wire                    susp_rise;

  wire [`GPL_W-1:0] sense_sel  = line_sel[`SEL_SENSE_LSB+`GPL_W-1:`SEL_SENSE_LSB];
  wire [`GPL_W-1:0] detach_sel = line_sel[`SEL_DETACH_LSB+`GPL_W-1:`SEL_DETACH_LSB];
  wire [`GPL_W-1:0] wake_sel   = line_sel[`SEL_WAKE_LSB+`GPL_W-1:`SEL_WAKE_LSB];
  wire [`GPL_W-1:0] pullup_sel = line_sel[`SEL_PULLUP_LSB+`GPL_W-1:`SEL_PULLUP_LSB];

  wire self_powered = ctrl[`CTRL_SELF_POWER];
  wire ext_pullup   = ctrl[`CTRL_PULLUP_EXT];

  //--------------------------------------------------------------
  // input synchronisers
  //--------------------------------------------------------------
  sync_2ff #(
    .WIDTH (`GPL_N)
  ) u_gpl_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (general_purpose_line_i),
    .sync_o    (gpl_sync)
  );

  sync_2ff #(
    .WIDTH (1)
  ) u_susp_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (host_suspend_i),
    .sync_o    (susp_sync)
  );

  wire power_raw = gpl_sync[sense_sel];
  // bus powered designs treat rail as present
  wire power_ok  = self_powered ? power_raw : 1'b1;
  wire detach    = gpl_sync[detach_sel];

  //--------------------------------------------------------------
  // link state machine
  //--------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      `ST_OFF: begin
        // attach only when ready and powered
        if (detach)
          next_state = `ST_DETACHED;
        else if (ctrl[`CTRL_READY] && power_ok)
          next_state = `ST_CONNECTED;
      end
      `ST_CONNECTED: begin
        if (detach)
          next_state = `ST_DETACHED;
        else if (!power_ok || !ctrl[`CTRL_READY])
          next_state = `ST_OFF;
        else if (susp_sync)
          next_state = `ST_SUSPENDED;
      end
      `ST_SUSPENDED: begin
        if (detach)
          next_state = `ST_DETACHED;
        else if (!power_ok || !ctrl[`CTRL_READY])
          next_state = `ST_OFF;
        else if (!susp_sync || bus_reset_i)
          next_state = `ST_CONNECTED;
      end
      default: begin
        if (!detach)
          next_state = `ST_OFF;
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (rst_i)
      state <= `ST_OFF;
    else
      state <= next_state;
  end

  wire attached  = (state == `ST_CONNECTED) || (state == `ST_SUSPENDED);
  wire suspended = (state == `ST_SUSPENDED);
  wire detached  = (state == `ST_DETACHED);

  //--------------------------------------------------------------
  // per line drive selection
  //--------------------------------------------------------------
  wire [`GPL_N-1:0] next_gpl_out;
  wire [`GPL_N-1:0] next_gpl_oe_n;

  wire wake_level = detached && ctrl[`CTRL_WAKE_REQ];

  genvar g;
  generate
    for (g = 0; g < `GPL_N; g = g + 1) begin : gen_line
      line_drive #(
        .LINE (g)
      ) u_line (
        .pullup_sel_i (pullup_sel),
        .wake_sel_i   (wake_sel),
        .ext_pullup_i (ext_pullup),
        .attached_i   (attached),
        .wake_level_i (wake_level),
        .drive_o      (next_gpl_out[g]),
        .oe_n_o       (next_gpl_oe_n[g])
      );
    end
  endgenerate

  //--------------------------------------------------------------
  // pins and outputs
  //--------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dplus_line_oe_n_o           <= 1'b1;
      dminus_line_oe_n_o          <= 1'b1;
      pullup_internal_o           <= 1'b0;
      general_purpose_line_o      <= {`GPL_N{1'b0}};
      general_purpose_line_oe_n_o <= {`GPL_N{1'b1}};
      peripheral_mode_o           <= 1'b1;
      audio_endpoints_o           <= 1'b0;
      max_power_setting_o         <= `MAX_POWER_RST;
      remote_wake_o               <= 1'b0;
      radio_enable_o              <= 1'b0;
      aux_power_enable_o          <= 1'b0;
    end else begin
      dplus_line_oe_n_o  <= !attached;
      dminus_line_oe_n_o <= !attached;
      pullup_internal_o  <= attached && !ext_pullup;
      general_purpose_line_o      <= next_gpl_out;
      general_purpose_line_oe_n_o <= next_gpl_oe_n;
      peripheral_mode_o   <= 1'b1;
      audio_endpoints_o   <= ctrl[`CTRL_AUDIO_EP];
      max_power_setting_o <= max_power;
      remote_wake_o       <= suspended && ctrl[`CTRL_REMOTE_WAKE];
      // radio stopped in bus powered suspend
      radio_enable_o      <= !(suspended && !self_powered);
      aux_power_enable_o  <= !suspended;
    end
  end

  //--------------------------------------------------------------
  // register port and interrupts
  //--------------------------------------------------------------
  // power idles present: bus powered after reset
  edge_event #(
    .IDLE (`POWER_IDLE)
  ) u_power_edge (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (power_ok),
    .rise_o    (power_rise),
    .fall_o    (power_fall)
  );

  edge_event #(
    .IDLE (`LINK_IDLE)
  ) u_detach_edge (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (detached),
    .rise_o    (detach_rise),
    .fall_o    (detach_fall)
  );

  edge_event #(
    .IDLE (`LINK_IDLE)
  ) u_susp_edge (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .level_i   (suspended),
    .rise_o    (susp_rise),
    .fall_o    ()
  );

  wire [`EV_N-1:0] events = {susp_rise, detach_fall, detach_rise, power_fall, power_rise};

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl       <= `CTRL_RST;
      line_sel   <= `LINE_SEL_RST;
      max_power  <= `MAX_POWER_RST;
      int_enable <= {`EV_N{1'b0}};
      int_status <= {`EV_N{1'b0}};
    end else begin
      if (reg_write_i) begin
        if (reg_addr_i == `REG_CTRL)
          ctrl <= reg_wdata_i[5:0];
        else if (reg_addr_i == `REG_LINE_SEL)
          line_sel <= reg_wdata_i;
        else if (reg_addr_i == `REG_MAX_POWER)
          max_power <= reg_wdata_i[`MAX_POWER_W-1:0];
        else if (reg_addr_i == `REG_INT_ENABLE)
          int_enable <= reg_wdata_i[`EV_N-1:0];
      end
      // set wins over clear
      if (reg_write_i && reg_addr_i == `REG_INT_CLEAR)
        int_status <= (int_status & ~reg_wdata_i[`EV_N-1:0]) | events;
      else
        int_status <= int_status | events;
    end
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
      irq_o       <= 1'b0;
    end else begin
      irq_o       <= |(int_status & int_enable);
      reg_rdata_o <= 16'h0000;
      if (reg_read_i) begin
        if (reg_addr_i == `REG_CTRL)
          reg_rdata_o <= {10'h000, ctrl};
        else if (reg_addr_i == `REG_LINE_SEL)
          reg_rdata_o <= line_sel;
        else if (reg_addr_i == `REG_MAX_POWER)
          reg_rdata_o <= {8'h00, max_power};
        else if (reg_addr_i == `REG_STATUS)
          reg_rdata_o <= {11'h000, susp_sync, detach, power_ok, state};
        else if (reg_addr_i == `REG_INT_STATUS)
          reg_rdata_o <= {11'h000, int_status};
        else if (reg_addr_i == `REG_INT_ENABLE)
          reg_rdata_o <= {11'h000, int_enable};
      end
    end
  end

endmodule

//--------------------------------------------------------------
// helper modules
//--------------------------------------------------------------
// two flop synchroniser
module sync_2ff #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;
  // only the second flop is read outside
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta   <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// rise and fall detector of a level
module edge_event #(
  parameter [0:0] IDLE = 1'b0
) (
  input  wire ref_clk_i,
  input  wire rst_i,
  input  wire level_i,
  output wire rise_o,
  output wire fall_o
);

  reg level_prev;
  // reset to the idle level, so no false edge follows reset
  always @(posedge ref_clk_i) begin
    if (rst_i)
      level_prev <= IDLE;
    else
      level_prev <= level_i;
  end

  assign rise_o = level_i && !level_prev;
  assign fall_o = !level_i && level_prev;

endmodule

// drive value and enable of one general purpose line
module line_drive #(
  parameter integer LINE = 0
) (
  input  wire [`GPL_W-1:0] pullup_sel_i,
  input  wire [`GPL_W-1:0] wake_sel_i,
  input  wire              ext_pullup_i,
  input  wire              attached_i,
  input  wire              wake_level_i,
  output reg               drive_o,
  output reg               oe_n_o
);

  // wake line driven, wins over pull-up
  always @* begin
    drive_o = 1'b0;
    oe_n_o  = 1'b1;
    if (wake_sel_i == LINE[`GPL_W-1:0]) begin
      drive_o = wake_level_i;
      oe_n_o  = 1'b0;
    end else if (ext_pullup_i && pullup_sel_i == LINE[`GPL_W-1:0]) begin
      drive_o = attached_i;
      oe_n_o  = !attached_i;
    end
  end

endmodule
`default_nettype wire

// [tb/usb_attach_props.sv]
// port assertions of the attach, detach and power control block
`timescale 1ns/1ps
`default_nettype none
`include "usb_attach_defs.vh"
module usb_attach_props (
  input wire logic                    ref_clk_i,
  input wire logic                    rst_i,
  input wire logic [`REG_ADDR_W-1:0]  reg_addr_i,
  input wire logic [15:0]             reg_wdata_i,
  input wire logic                    reg_write_i,
  input wire logic                    reg_read_i,
  input wire logic [15:0]             reg_rdata_o,
  input wire logic                    dplus_line_oe_n_o,
  input wire logic                    dminus_line_oe_n_o,
  input wire logic                    pullup_internal_o,
  input wire logic                    peripheral_mode_o,
  input wire logic                    audio_endpoints_o,
  input wire logic [`MAX_POWER_W-1:0] max_power_setting_o,
  input wire logic                    remote_wake_o,
  input wire logic                    radio_enable_o,
  input wire logic                    aux_power_enable_o,
  input wire logic                    irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_ctrl; reg_write_i && reg_addr_i == `REG_CTRL; endsequence
  sequence wr_maxp; reg_write_i && reg_addr_i == `REG_MAX_POWER; endsequence
  sequence rd_maxp; reg_read_i && reg_addr_i == `REG_MAX_POWER; endsequence
  periph_only_a: assert property (peripheral_mode_o)
    else $error("peripheral mode low");
  audio_select_a: assert property (wr_ctrl |-> ##2 audio_endpoints_o == $past(reg_wdata_i[3], 2))
    else $error("audio endpoint select wrong");
  maxp_write_a: assert property (wr_maxp |-> ##2 max_power_setting_o == $past(reg_wdata_i[7:0], 2))
    else $error("max power not taken");
  maxp_read_a: assert property (rd_maxp |=> reg_rdata_o == {8'h00, max_power_setting_o})
    else $error("max power readback wrong");
  reset_state_a: assert property (disable iff (1'b0) rst_i |=> max_power_setting_o == 8'h32 &&
    !pullup_internal_o && dplus_line_oe_n_o && !irq_o)
    else $error("reset state wrong");
  pullup_line_a: assert property (pullup_internal_o |-> !dplus_line_oe_n_o)
    else $error("pullup while lines floating");
  line_pair_a: assert property (dplus_line_oe_n_o == dminus_line_oe_n_o)
    else $error("data line enables differ");
  radio_aux_a: assert property (!radio_enable_o |-> !aux_power_enable_o)
    else $error("aux on while radio stopped");
  wake_suspend_a: assert property (remote_wake_o |-> !aux_power_enable_o && !dplus_line_oe_n_o)
    else $error("remote wake outside suspend");
  read_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
endmodule
bind usb_attach_detach_control usb_attach_props u_props (.ref_clk_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .dplus_line_oe_n_o, .dminus_line_oe_n_o,
  .pullup_internal_o, .peripheral_mode_o, .audio_endpoints_o, .max_power_setting_o,
  .remote_wake_o, .radio_enable_o, .aux_power_enable_o, .irq_o);
`default_nettype wire

// [tb/usb_host_model.sv]
// upstream host model: suspends and resets an attached device on request
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic pullup_i,
  input  wire logic dplus_oe_n_i,
  input  wire logic suspend_req_i,
  input  wire logic reset_req_i,
  output logic      host_suspend_o,
  output logic      bus_reset_o
);
  always @(posedge ref_clk_i) begin
    host_suspend_o <= !rst_i && suspend_req_i && pullup_i && !dplus_oe_n_i;
    bus_reset_o <= !rst_i && reset_req_i && pullup_i && !dplus_oe_n_i;
  end
endmodule
`default_nettype wire

// [tb/usb_attach_detach_control_tb_top.sv]
// self-checking bench of the attach, detach and power control block
`timescale 1ns/1ps
`default_nettype none
`include "usb_attach_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module usb_attach_detach_control_tb_top;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, sreq = 1'b0, rreq = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, gpi = 16'h0000, rdata, gpo, gpoe;
  logic [7:0] maxp;
  logic dpoe, dmoe, pu, susp, busrst, periph, audio, rwake, radio, aux, irq;
  int mismatches = 0, check_count = 0, seed = 38, i, v;
  int pq[$];
  always #4 clk = ~clk;
  usb_attach_detach_control u_dut (.ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata),
    .general_purpose_line_i(gpi), .general_purpose_line_o(gpo),
    .general_purpose_line_oe_n_o(gpoe), .dplus_line_oe_n_o(dpoe), .dminus_line_oe_n_o(dmoe),
    .pullup_internal_o(pu), .host_suspend_i(susp), .bus_reset_i(busrst),
    .peripheral_mode_o(periph), .audio_endpoints_o(audio), .max_power_setting_o(maxp),
    .remote_wake_o(rwake), .radio_enable_o(radio), .aux_power_enable_o(aux), .irq_o(irq));
  usb_host_model u_host (.ref_clk_i(clk), .rst_i(rst), .pullup_i(pu), .dplus_oe_n_i(dpoe),
    .suspend_req_i(sreq), .reset_req_i(rreq), .host_suspend_o(susp), .bus_reset_o(busrst));
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input [3:0] a, input int e, input string n);
    @(posedge clk);
    addr <= a; re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    `CHK(n, e[15:0], rdata)
  endtask
  task pins(input [15:0] p);
    @(posedge clk);
    gpi <= p;
    wt(6);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wt(2);
    `CHK("periph", 1'b1, periph)
    rd(`REG_MAX_POWER, 'h32, "maxp");
    rd(`REG_CTRL, 0, "ctrl");
    rd(4'hf, 0, "unmapped");
    rd(`REG_INT_CLEAR, 0, "clear");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      pq.push_back(v & 'hff);
      wr(`REG_MAX_POWER, v[15:0]);
      wt(2);
      `CHK("maxp_o", pq[0], maxp)
      rd(`REG_MAX_POWER, pq.pop_front(), "maxp_rd");
    end
    `CHK("pullup_idle", 1'b0, pu)
    wr(`REG_INT_ENABLE, 16'h001f);
    wr(`REG_CTRL, 16'h0009);
    wr(`REG_INT_CLEAR, 16'h001f);
    wt(3);
    `CHK("pullup", 1'b1, pu)
    `CHK("dplus_oe", 1'b0, dpoe)
    `CHK("audio", 1'b1, audio)
    `CHK("irq_clr", 1'b0, irq)
    rd(`REG_STATUS, 'h5, "status");
    wr(`REG_LINE_SEL, 16'h0730);
    pins(16'h0008);
    `CHK("dplus_float", 1'b1, dpoe)
    `CHK("dminus_float", 1'b1, dmoe)
    `CHK("pullup_off", 1'b0, pu)
    `CHK("wake_idle", 1'b0, gpo[7])
    `CHK("irq_detach", 1'b1, irq)
    rd(`REG_INT_STATUS, 'h4, "int_detach");
    wr(`REG_CTRL, 16'h0031);
    wr(`REG_INT_CLEAR, 16'h0004);
    wt(3);
    `CHK("wake_on", 1'b1, gpo[7])
    `CHK("wake_oe", 1'b0, gpoe[7])
    `CHK("rwake_detached", 1'b0, rwake)
    `CHK("irq_after_clr", 1'b0, irq)
    pins(16'h0000);
    `CHK("wake_off", 1'b0, gpo[7])
    `CHK("pullup_back", 1'b1, pu)
    `CHK("audio_off", 1'b0, audio)
    rd(`REG_INT_STATUS, 'h8, "int_attach");
    wr(`REG_INT_ENABLE, 16'h0000);
    wt(2);
    `CHK("irq_masked", 1'b0, irq)
    wr(`REG_LINE_SEL, 16'h5732);
    wr(`REG_CTRL, 16'h0005);
    wt(6);
    `CHK("self_no_power", 1'b0, pu)
    pins(16'h0004);
    `CHK("self_power", 1'b1, pu)
    wr(`REG_CTRL, 16'h0003);
    wt(4);
    `CHK("ext_int_off", 1'b0, pu)
    `CHK("ext_oe", 1'b0, gpoe[5])
    `CHK("ext_drive", 1'b1, gpo[5])
    wr(`REG_CTRL, 16'h0021);
    wt(4);
    @(posedge clk);
    sreq <= 1'b1;
    wt(8);
    `CHK("radio_susp", 1'b0, radio)
    `CHK("aux_susp", 1'b0, aux)
    `CHK("rwake", 1'b1, rwake)
    @(posedge clk);
    sreq <= 1'b0;
    rreq <= 1'b1;
    wt(8);
    `CHK("radio_resume", 1'b1, radio)
    @(posedge clk);
    rreq <= 1'b0;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end
endmodule
`default_nettype wire
